// ---- ubd_cfg.svh ----
// Timing counts and field positions for the UART break detector.
`ifndef UBD_CFG_SVH
`define UBD_CFG_SVH
`define UBD_DATA_BITS       4'h8
`define UBD_PARITY_BITS     4'h1
`define UBD_STOP_BITS       4'h1
`define UBD_FRAME_BITS      (4'h1 + `UBD_DATA_BITS + `UBD_PARITY_BITS + `UBD_STOP_BITS)
`define UBD_OVERSAMPLE      8'h10
`define UBD_DIV_RESET       16'h0008
`define UBD_LSR_DR_BIT      0
`define UBD_LSR_BI_BIT      4
`define UBD_LSR_RESET       8'h00
`define UBD_RBR_RESET       8'h00
`endif

// ---- ubd_pkg.sv ----
// Types shared by the UART break detector files.
package ubd_pkg;
  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_BREAK = 3'b011,
    RX_WAITH = 3'b100
  } ubd_rx_state_t;

  // Software access strobes toward the status and buffer registers.
  typedef struct packed
  {
    logic lsr_rd;
    logic rbr_rd;
  } ubd_sw_t;

  // Status and data seen by software.
  typedef struct packed
  {
    logic [7:0] lsr;
    logic [7:0] rbr;
    logic       irq;
    logic       in_break;
  } ubd_stat_t;
endpackage

// ---- ubd_sample_gen.sv ----
// Baud tick generator: one pulse per oversampled bit slice.
`include "ubd_cfg.svh"
module ubd_sample_gen
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] divisor_i,
  output logic             tick_o
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } ubd_sg_state_t;

  ubd_sg_state_t st_reg;
  ubd_sg_state_t st_next;

  // Counts down the divisor and pulses once per wrap.
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt <= 16'h0001)
    begin
      st_next.cnt  = (divisor_i == 16'h0000) ? 16'h0001 : divisor_i;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule

// ---- ubd_break_rx.sv ----
// UART receiver with single-report break detection and clean break exit.
`include "ubd_cfg.svh"
// Notes on behaviour
// [RULE_01] Line low longer than start, data, parity and stop bits is a break.
// [RULE_02] A break lasts until the receive line returns to one.
// [RULE_03] On break the break indicator in the line status register is set.
// [RULE_04] Reading the line status register clears the break indicator.
// [RULE_05] Reading the receive buffer clears the character available flag.
// [RULE_06] Cleared flags are not set again during the same break.
// [RULE_07] The receive buffer reads zero right after a break is reported.
// [RULE_08] No further interrupts while the same break continues.
// [RULE_09] Software reads buffer, waits a character, reads again; break lasts two characters.
// [RULE_10] No spurious character is loaded when the line rises after a break.
module ubd_break_rx
(
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             rxd_i,
  input  wire logic [15:0]      divisor_i,
  input  wire ubd_pkg::ubd_sw_t sw_i,
  output ubd_pkg::ubd_stat_t    stat_o
);
  // All state of the receiver except the tick counter in u_sample_gen lives in one register word.
  // The flags bi and dr are the break indicator and the character available bit.
  // The fields lsr_q and rbr_q are the copies that software sees.
  // Keeping them as registers means the status outputs never glitch.
  // They cannot move while the receive timing steps on inside a cycle.
  // The field all_zero remembers whether every sample of the frame was low.
  // That is what tells a break from a framing error that carried some data.
  // The field bitn counts the bit being received, one for the first data bit.
  // The field sub counts oversampling slices inside the present bit.
  // The field irq is the interrupt level handed to the host.
  typedef struct packed
  {
    ubd_pkg::ubd_rx_state_t fsm;
    logic [7:0]             sub;
    logic [3:0]             bitn;
    logic [7:0]             shift;
    logic                   all_zero;
    logic                   dr;
    logic                   bi;
    logic [7:0]             rbr;
    logic [7:0]             lsr_q;
    logic [7:0]             rbr_q;
    logic                   irq;
  } ubd_rx_regs_t;

  ubd_rx_regs_t st_reg;
  ubd_rx_regs_t st_next;
  logic         tick;
  logic         mid_start;
  logic         bit_end;
  logic         data_bit;
  logic         last_bit;
  logic         frame_low;
  logic         line_high;

  // Half a bit after the falling edge the start bit is looked at again.
  assign mid_start = tick && (st_reg.sub == (`UBD_OVERSAMPLE >> 1) - 8'h01);

  // Centre of a data, parity or stop bit, sixteen slices after the last one.
  assign bit_end = tick && (st_reg.sub == `UBD_OVERSAMPLE - 8'h01);

  // Bit numbers one to eight carry data; later ones are parity and stop.
  assign data_bit = (st_reg.bitn <= `UBD_DATA_BITS);

  // The last stop bit closes the frame.
  assign last_bit = (st_reg.bitn == `UBD_FRAME_BITS - 4'h1);

  // Every earlier sample and this one low: the frame held no one at all.
  assign frame_low = st_reg.all_zero && !rxd_i; // RULE_01

  // The receive line back at one, the only way out of a break.
  assign line_high = rxd_i; // RULE_02

  // Oversampling tick: sixteen ticks make one bit on the line.
  // A divisor of one gives a tick on every clock.
  ubd_sample_gen u_sample_gen
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .divisor_i (divisor_i),
    .tick_o    (tick)
  );

  // Frame receiver, break tracking and software-side flag handling.
  // A break is taken only at the last stop sample, so a frame that merely
  // has a zero data byte and a good stop bit is a normal character.
  // Once in the break state nothing sets a flag again, which keeps
  // a long break from being reported once per character period.
  // The line rising ends the break through idle, so the next falling edge
  // starts a fresh frame instead of loading leftover samples.
  // Software reads are applied first so that an event in the same cycle
  // overrides them; the set of a flag always wins over its clear.
  always_comb
  begin
    st_next = st_reg;
    // Software reads clear flags; a fresh event in the same cycle wins below.
    if (sw_i.lsr_rd)
    begin
      st_next.bi = 1'b0; // RULE_04
    end
    if (sw_i.rbr_rd)
    begin
      st_next.dr = 1'b0; // RULE_05
    end
    if (tick)
    begin
      st_next.sub = st_reg.sub + 8'h01;
      case (st_reg.fsm)
        ubd_pkg::RX_IDLE:
        begin
          st_next.sub = 8'h00;
          if (!rxd_i)
          begin
            st_next.fsm = ubd_pkg::RX_START;
          end
        end
        ubd_pkg::RX_START:
        begin
          // Mid start bit: confirm it, else it was a glitch.
          if (mid_start)
          begin
            st_next.sub      = 8'h00;
            st_next.bitn     = 4'h1;
            st_next.all_zero = 1'b1;
            st_next.fsm      = rxd_i ? ubd_pkg::RX_IDLE : ubd_pkg::RX_DATA;
          end
        end
        ubd_pkg::RX_DATA:
        begin
          if (bit_end)
          begin
            st_next.sub      = 8'h00;
            st_next.bitn     = st_reg.bitn + 4'h1;
            st_next.all_zero = st_reg.all_zero & ~rxd_i;
            if (data_bit)
            begin
              st_next.shift = {rxd_i, st_reg.shift[7:1]};
            end
            if (last_bit)
            begin
              // Last stop bit sampled: whole frame low means a break.
              if (frame_low)
              begin
                st_next.fsm = ubd_pkg::RX_BREAK; // RULE_01
                st_next.bi  = 1'b1;              // RULE_03
                st_next.dr  = 1'b1;
                st_next.rbr = `UBD_RBR_RESET;   // RULE_07
                st_next.irq = 1'b1;
              end
              else
              begin
                st_next.fsm = rxd_i ? ubd_pkg::RX_IDLE : ubd_pkg::RX_WAITH;
                st_next.rbr = st_reg.shift;
                st_next.dr  = 1'b1;
                st_next.irq = 1'b1;
              end
            end
          end
        end
        ubd_pkg::RX_BREAK:
        begin
          // Stays here silently until the line rises; no re-set of flags.
          // Keeping sub cleared stops the frame counter from running on.
          st_next.sub = 8'h00; // RULE_06 RULE_08
          if (line_high)
          begin
            st_next.fsm = ubd_pkg::RX_IDLE; // RULE_02 RULE_10
          end
        end
        ubd_pkg::RX_WAITH:
        begin
          // Framing error line stuck low: wait for idle before next start.
          // A zero stop bit with some data is not a break; the data was kept.
          st_next.sub = 8'h00;
          if (rxd_i)
          begin
            st_next.fsm = ubd_pkg::RX_IDLE;
          end
        end
        default:
        begin
          st_next.fsm = ubd_pkg::RX_IDLE;
        end
      endcase
    end
    // Interrupt follows any pending flag; it clears with the flags.
    // It is set only together with a flag, and in the break state no flag is
    // set, so a continuing break raises no further interrupt once both are read.
    if (!st_next.bi && !st_next.dr)
    begin
      st_next.irq = 1'b0; // RULE_08
    end
    st_next.lsr_q = `UBD_LSR_RESET;
    st_next.lsr_q[`UBD_LSR_BI_BIT] = st_next.bi;
    st_next.lsr_q[`UBD_LSR_DR_BIT] = st_next.dr;
    st_next.rbr_q = st_next.rbr;
  end

  // State register.
  // The reset branch loads constants only, so the asynchronous path is clean.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs lsr, rbr and irq come straight from flip-flops.
  // The break level is decoded from the state register alone, so it is clean.
  always_comb
  begin
    stat_o.lsr      = st_reg.lsr_q;
    stat_o.rbr      = st_reg.rbr_q;
    stat_o.irq      = st_reg.irq;
    stat_o.in_break = (st_reg.fsm == ubd_pkg::RX_BREAK);
  end
endmodule

// ---- ubd_break_rx_assertions.sv ----
// Checker that watches the break detector's ports.
module ubd_break_chk
(
  input wire logic               sys_clk_i,
  input wire logic               rstn_i,
  input wire logic               rxd_i,
  input wire logic [15:0]        divisor_i,
  input wire ubd_pkg::ubd_sw_t   sw_i,
  input wire ubd_pkg::ubd_stat_t stat_o
);
  logic [15:0] low_cnt_reg;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Counts clocks that the line has stayed low, saturating.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      low_cnt_reg <= 16'h0000;
    else
      low_cnt_reg <= rxd_i ? 16'h0000 : low_cnt_reg + {15'h0000, ~&low_cnt_reg};
  end
  sequence s_rpt;
    $rose(stat_o.in_break);
  endsequence
  chk_low_frame: assert property (s_rpt |-> low_cnt_reg >= 16'h00a0) else $error("break too early");
  chk_end_high: assert property ($fell(stat_o.in_break) |-> rxd_i) else $error("break ended low");
  chk_break_rpt: assert property (s_rpt |-> stat_o.lsr == 8'h11 && stat_o.rbr == 8'h00)
    else $error("break report wrong");
  chk_bi_clear: assert property (sw_i.lsr_rd && stat_o.in_break |=> !stat_o.lsr[4]) else $error("bi kept");
  chk_dr_clear: assert property (sw_i.rbr_rd && stat_o.in_break |=> !stat_o.lsr[0]) else $error("dr kept");
  chk_bi_quiet: assert property (stat_o.in_break && !stat_o.lsr[4] |=> !stat_o.lsr[4]) else $error("bi again");
  chk_irq_quiet: assert property (stat_o.in_break && !stat_o.irq |=> !stat_o.irq) else $error("irq again");
  chk_no_ghost: assert property ($fell(stat_o.in_break) && !stat_o.lsr[0] |=> !stat_o.lsr[0] [*8])
    else $error("ghost char");
endmodule
bind ubd_break_rx ubd_break_chk chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rxd_i(rxd_i),
  .divisor_i(divisor_i), .sw_i(sw_i), .stat_o(stat_o));

// ---- ubd_tx_model.sv ----
// Remote serial transmitter model driving the receive line.
module ubd_tx_model
(
  input  wire logic sys_clk_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line rests high between frames.
  initial rxd_o = 1'b1;
  // Sends start, eight bits LSB first, parity and stop, 16 clocks each.
  task automatic send_byte(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ^d, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd_o <= f[i];
      repeat (16) @(negedge sys_clk_i);
    end
  endtask
  // Holds the line low for n clocks, then releases it high.
  task automatic hold_low(input int n);
    rxd_o <= 1'b0;
    repeat (n) @(negedge sys_clk_i);
    rxd_o <= 1'b1;
  endtask
endmodule

// ---- uart_break_detection_bench.sv ----
// Self-checking bench for the break detector.
module uart_break_detection_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic               rxd;
  ubd_pkg::ubd_sw_t   sw = '0;
  ubd_pkg::ubd_stat_t st;
  int                 errors = 0;
  int                 check_count = 0;
  // Clock of 4 ns period.
  always #2 sys_clk_i = ~sys_clk_i;
  ubd_tx_model tx (.sys_clk_i(sys_clk_i), .rxd_o(rxd));
  ubd_break_rx uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rxd_i(rxd), .divisor_i(16'h0001),
    .sw_i(sw), .stat_o(st));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pulses one read strobe, then lets the flags settle.
  task automatic rd(input logic lsr);
    sw.lsr_rd = lsr;
    sw.rbr_rd = !lsr;
    @(negedge sys_clk_i);
    sw = '0;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // A normal character lands and its flag clears on a buffer read.
  task automatic t_char(input logic [7:0] d);
    tx.send_byte(d);
    repeat (4) @(negedge sys_clk_i);
    chk(st.rbr, d);
    chk(st.lsr, 8'h01);
    chk({7'h00, st.irq}, 8'h01);
    rd(1'b0);
    chk(st.lsr, 8'h00);
    chk({7'h00, st.irq}, 8'h00);
  endtask
  // A break of four frames is reported once and ends cleanly.
  task automatic t_break();
    fork
      tx.hold_low(704);
      begin
        repeat (150) @(negedge sys_clk_i);
        chk({7'h00, st.in_break}, 8'h00);
        for (int i = 0; i < 300 && st.in_break !== 1'b1; i++)
          @(negedge sys_clk_i);
        chk({7'h00, st.in_break}, 8'h01);
        if (st.in_break !== 1'b1)
          conclude();
        chk(st.lsr, 8'h11);
        chk(st.rbr, 8'h00);
        chk({7'h00, st.irq}, 8'h01);
        rd(1'b1);
        chk(st.lsr, 8'h01);
        rd(1'b0);
        chk(st.lsr, 8'h00);
        repeat (200) @(negedge sys_clk_i);
        chk(st.lsr, 8'h00);
        chk({7'h00, st.irq}, 8'h00);
        rd(1'b0);
        chk(st.rbr, 8'h00);
        chk({7'h00, st.in_break}, 8'h01);
      end
    join
    repeat (400) @(negedge sys_clk_i);
    chk({7'h00, st.in_break}, 8'h00);
    chk(st.lsr, 8'h00);
  endtask
  // Main sequence: reset, then each scenario.
  initial
  begin
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    @(negedge sys_clk_i);
    t_char(8'ha5);
    t_break();
    t_char(8'h3c);
    conclude();
  end
endmodule
